// file: hw/ifc_pkg.sv
// Purpose: constants for the indirect fabric register access engine
// Assumes: 32-bit APB data, one aligned word per register
// Notes: command register bit layout and offsets live here
package ifc_pkg;
  localparam logic [11:0] OFS_DATA = 12'h1ac;
  localparam logic [11:0] OFS_CMD = 12'h1b0;
  localparam int BIT_PENDING = 31;
  localparam int BIT_DIR = 30;
  localparam int BIT_STEP_UP = 29;
  localparam int BIT_STEP_DOWN = 28;
  localparam int LANE_LSB = 16;
  localparam int LANE_W = 4;
  localparam int INDEX_W = 16;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [15:0] RST_INDEX = 16'h0000;
  localparam logic [3:0] RST_LANE = 4'h0;
  localparam logic RST_DIR = 1'b0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } ifc_state_t;
endpackage

// file: hw/ifc_engine.sv
// Purpose: APB slave giving indirect access to the fabric register array
// Assumes: fabric array on the same clock, request held until acknowledged
// Notes: zero-wait APB answer, read data registered in the setup cycle
//
// Summary of operation
// - writing one to op_pending starts a fabric access of the chosen direction
// - op_pending stays set through the access and self-clears when done
// - read data is in the data register by the cycle op_pending clears
// - direction_select zero is write, one is read, resets to zero
// - step-up: data write launches access, index increments after the write
// - step-up: data read increments index and launches the next fabric read
// - step-down: data write launches access, index decrements after the write
// - step-down: data read decrements index and launches the next read
// - step-up wins when both step enables are set
// - four-bit lane_select resets to zero, masks bytes on fabric writes
// - lane bit n governs data bits 8n+7 down to 8n
// - target_index is a 16-bit field in bits 15:0, resets to zero
// - data read returns fabric data when reading, else last host write
// - data register is 32-bit read/write at its own offset, resets to zero
`timescale 1ns/100ps
`default_nettype none
module ifc_engine
#(
  parameter int ADDR_W = 12
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic FAB_REQ,
  output logic FAB_WE,
  output logic [ifc_pkg::INDEX_W-1:0] FAB_INDEX,
  output logic [31:0] FAB_WDATA,
  output logic [ifc_pkg::LANE_W-1:0] FAB_LANES,
  input wire logic FAB_ACK,
  input wire logic [31:0] FAB_RDATA
);
  import ifc_pkg::*;

  // offsets need nine bits; wider buses alias above bit 11
  if (ADDR_W < 9 || ADDR_W > 32)
  begin
    $error("ADDR_W must cover the register offsets");
  end

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  ifc_state_t state_q, state_d;
  logic pending_q, pending_d;
  logic dir_q, up_q, down_q, fab_we_q;
  logic [3:0] lane_q;
  logic [15:0] index_q, index_d;
  logic [31:0] wdata_q, rdata_q;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d;
  logic fab_req_q, fab_req_d;

  wire logic [11:0] ofs = 12'(PADDR);
  wire logic hit_data = ofs == OFS_DATA;
  wire logic hit_cmd = ofs == OFS_CMD;
  wire logic setup = PSEL && !PENABLE;
  wire logic commit = PSEL && PENABLE && pready_q;
  wire logic wr_data = commit && PWRITE && hit_data;
  wire logic wr_cmd = commit && PWRITE && hit_cmd;
  wire logic rd_data = commit && !PWRITE && hit_data;
  // step-up takes precedence
  wire logic step_on = up_q || down_q;
  wire logic [15:0] index_step = up_q ? index_q + 16'h0001
                                      : index_q - 16'h0001;
  wire logic [31:0] cmd_view = {pending_q, dir_q, up_q, down_q, 8'h00,
                                lane_q, index_q};
  wire logic [31:0] cmd_new = strb_merge(cmd_view, PWDATA, PSTRB);
  wire logic fab_done = state_q == ST_ACCESS && FAB_ACK;
  wire logic start = (wr_cmd && cmd_new[BIT_PENDING])
                  || ((wr_data || rd_data) && step_on);
  wire logic [31:0] data_view = dir_q == DIR_READ ? rdata_q : wdata_q;

  // a start in the completion cycle wins, so no launch is lost
  assign pending_d = start || (pending_q && !fab_done);
  assign prdata_d = !setup || PWRITE ? prdata_q
                  : hit_data ? data_view
                  : hit_cmd ? cmd_view : 32'h0000_0000;
  assign pslverr_d = setup ? !(hit_data || hit_cmd) : pslverr_q;

  always_comb
  begin
    index_d = index_q;
    if (wr_cmd)
      index_d = cmd_new[INDEX_W-1:0];
    else if (rd_data && step_on)
      index_d = index_step;
    else if (fab_done && dir_q == DIR_WRITE && step_on)
      index_d = index_step;
  end

  always_comb
  begin
    state_d = state_q;
    fab_req_d = fab_req_q;
    case (state_q)
      ST_IDLE:
      begin
        if (pending_q)
        begin
          state_d = ST_ACCESS;
          fab_req_d = 1'b1;
        end
      end
      ST_ACCESS:
      begin
        if (FAB_ACK)
        begin
          state_d = ST_IDLE;
          fab_req_d = 1'b0;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        fab_req_d = 1'b0;
      end
    endcase
  end

  // command fields other than pending and index
  wire logic dir_d = wr_cmd ? cmd_new[BIT_DIR] : dir_q;
  wire logic up_d = wr_cmd ? cmd_new[BIT_STEP_UP] : up_q;
  wire logic down_d = wr_cmd ? cmd_new[BIT_STEP_DOWN] : down_q;
  wire logic [3:0] lane_d = wr_cmd ? cmd_new[LANE_LSB +: LANE_W] : lane_q;
  // direction kept in its own flop so the port needs no gate
  wire logic fab_we_d = wr_cmd ? cmd_new[BIT_DIR] == DIR_WRITE : fab_we_q;
  wire logic [31:0] wdata_d = wr_data ? strb_merge(wdata_q, PWDATA, PSTRB)
                                      : wdata_q;
  // captured on the ack edge, same edge pending clears
  wire logic [31:0] rdata_d = fab_done && dir_q == DIR_READ ? FAB_RDATA
                                                            : rdata_q;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pending_q <= 1'b0;
    end
    else
    begin
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      fab_req_q <= 1'b0;
    end
    else
    begin
      fab_req_q <= fab_req_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      index_q <= RST_INDEX;
    end
    else
    begin
      index_q <= index_d;
    end
  end

  // zero wait states: ready follows every setup cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      dir_q <= RST_DIR;
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      up_q <= 1'b0;
    end
    else
    begin
      up_q <= up_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      down_q <= 1'b0;
    end
    else
    begin
      down_q <= down_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      lane_q <= RST_LANE;
    end
    else
    begin
      lane_q <= lane_d;
    end
  end

  // reset direction is write, so the port resets high
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      fab_we_q <= 1'b1;
    end
    else
    begin
      fab_we_q <= fab_we_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wdata_q <= RST_DATA;
    end
    else
    begin
      wdata_q <= wdata_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rdata_q <= RST_DATA;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign FAB_REQ = fab_req_q;
  assign FAB_WE = fab_we_q;
  assign FAB_INDEX = index_q;
  assign FAB_WDATA = wdata_q;
  // fabric array writes only lanes set here
  assign FAB_LANES = lane_q;

endmodule
`default_nettype wire

// file: test/ifc_engine_chk.sv
// Purpose: port assertions for ifc_engine
// Assumes: host keeps the command still while busy
// Notes: bound to every ifc_engine instance below
`timescale 1ns/100ps
`default_nettype none
module ifc_engine_chk
  import ifc_pkg::*;
#(parameter int ADDR_W = 12)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FAB_REQ,
  input wire logic FAB_WE,
  input wire logic [ifc_pkg::INDEX_W-1:0] FAB_INDEX,
  input wire logic FAB_ACK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire mapped = PADDR == OFS_DATA || PADDR == OFS_CMD;
  a_ready_zero: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready late");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_err_map: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR)
    else $error("unmapped not refused");
  a_ok_map: assert property (PSEL && !PENABLE && mapped |=> !PSLVERR)
    else $error("mapped refused");
  a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read data");
  a_req_hold: assert property (FAB_REQ && !FAB_ACK |=> FAB_REQ)
    else $error("request dropped");
  a_req_drop: assert property (FAB_REQ && FAB_ACK |=> !FAB_REQ)
    else $error("request kept");
  a_req_args: assert property (FAB_REQ && !FAB_ACK |=>
    $stable(FAB_INDEX) && $stable(FAB_WE)) else $error("request moved");
  a_req_cause: assert property (
    $rose(FAB_REQ) |-> $past(PENABLE, 2))
    else $error("launch without access");
  a_index_cause: assert property ($changed(FAB_INDEX) |->
    $past(PSEL) || $past(FAB_REQ)) else $error("index moved alone");
endmodule
bind ifc_engine ifc_engine_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// file: test/ifc_fabric_model.sv
// Purpose: fabric register array behind the engine
// Assumes: sixteen words, low index bits select
// Notes: ack dly+1 cycles after req rises; rdata inverted when not acking
`timescale 1ns/100ps
`default_nettype none
module ifc_fabric_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] index,
  input wire logic [31:0] wdata,
  input wire logic [3:0] lanes,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [16];
  logic [3:0] cnt_q;
  wire [31:0] word = mem[index[3:0]];
  // stale data never looks valid
  assign rdata = ack ? word : ~word;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end
    else
    begin
      ack <= req && !ack && cnt_q == dly;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      for (int b = 0; b < 4; b++)
        if (ack && we && lanes[b])
          mem[index[3:0]][8*b +: 8] <= wdata[8*b +: 8];
    end
  end
endmodule
`default_nettype wire

// file: test/indirect_fabric_csr_access_tb_top.sv
// Purpose: self-checking bench for ifc_engine
// Assumes: zero-wait APB slave
// Notes: seeded random data words
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h seen %h", n, e, s); end end
module indirect_fabric_csr_access_tb_top;
  import ifc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd, w0, w1, prdata, fab_wdata, fab_rdata;
  logic pready, pslverr, fab_req, fab_we, fab_ack;
  logic [15:0] fab_index;
  logic [3:0] fab_lanes, dly = 4'h0, pstrb = 4'hf;
  int failures = 0, tests_run = 0, cyc = 0, seed = 82;
  always #12.5 clk = ~clk;
  ifc_engine dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FAB_REQ(fab_req),
    .FAB_WE(fab_we), .FAB_INDEX(fab_index), .FAB_WDATA(fab_wdata),
    .FAB_LANES(fab_lanes), .FAB_ACK(fab_ack), .FAB_RDATA(fab_rdata));
  ifc_fabric_model fab_u (.clk(clk), .rst_n(rst_n), .req(fab_req),
    .we(fab_we), .index(fab_index), .wdata(fab_wdata), .lanes(fab_lanes),
    .dly(dly), .ack(fab_ack), .rdata(fab_rdata));
  function automatic logic [31:0] cmd(logic p, d, u, n, logic [3:0] l,
    logic [15:0] i);
    return {p, d, u, n, 8'h0, l, i};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    repeat (20)
    begin
      apb(1'b0, OFS_CMD, 32'h0);
      if (rd[31] === 1'b0) break;
    end
  endtask
  task finish_test;
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      finish_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    w0 = $random(seed);
    w1 = $random(seed);
    apb(0, OFS_CMD, 0);
    `CHK("cmd reset", 32'h0, rd)
    apb(0, OFS_DATA, 0);
    `CHK("data reset", 32'h0, rd)
    apb(0, 12'h1b4, 0);
    `CHK("refused", 1'b1, err)
    apb(1, OFS_DATA, w0);
    apb(1, OFS_CMD, cmd(1, DIR_WRITE, 0, 0, 4'h5, 16'h3));
    wait_idle;
    `CHK("idle", 1'b0, rd[31])
    apb(1, OFS_CMD, cmd(1, DIR_READ, 0, 0, 4'hf, 16'h3));
    wait_idle;
    apb(0, OFS_DATA, 0);
    `CHK("lanes", w0 & 32'h00ff00ff, rd)
    dly <= 4'h3;
    apb(1, OFS_CMD, cmd(0, DIR_WRITE, 1, 1, 4'hf, 16'hffff));
    apb(1, OFS_DATA, w0);
    wait_idle;
    apb(1, OFS_DATA, w1);
    wait_idle;
    `CHK("step up", cmd(0, 0, 1, 1, 4'hf, 16'h1), rd)
    apb(1, OFS_CMD, cmd(1, DIR_READ, 0, 1, 4'hf, 16'h0));
    wait_idle;
    apb(0, OFS_DATA, 0);
    `CHK("read down", w1, rd)
    apb(0, OFS_CMD, 0);
    `CHK("step down", cmd(1, 1, 0, 1, 4'hf, 16'hffff), rd)
    wait_idle;
    apb(1, OFS_CMD, cmd(0, DIR_READ, 0, 0, 4'hf, 16'hffff));
    apb(0, OFS_DATA, 0);
    `CHK("fabric word", w0, rd)
    apb(1, OFS_DATA, w1);
    apb(0, OFS_CMD, 0);
    `CHK("no step", cmd(0, 1, 0, 0, 4'hf, 16'hffff), rd)
    pstrb <= 4'h3;
    apb(1, OFS_DATA, w0);
    pstrb <= 4'hf;
    apb(1, OFS_CMD, cmd(0, DIR_WRITE, 0, 0, 4'hf, 16'h0));
    apb(0, OFS_DATA, 0);
    `CHK("strobe", {w1[31:16], w0[15:0]}, rd)
    finish_test;
  end
endmodule
`default_nettype wire
